// ==== core/kbi_pkg.sv ====
// shared types of the keyboard interrupt block
package kbi_pkg;

  typedef logic [4:0] kbi_pins_t;

  typedef enum logic [1:0] {
    KBI_WB_IDLE = 2'b01,
    KBI_WB_ACK  = 2'b10
  } kbi_wb_state_t;

endpackage

// ==== core/kbi_regs.svh ====
// register indices, field positions, reset values and sizes of the keyboard interrupt block
`ifndef KBI_REGS_SVH
`define KBI_REGS_SVH

// ********************************************************************
// register indices (byte address is four times the index)
// ********************************************************************
`define KBI_IDX_STATUS_CTRL 8'h1B
`define KBI_IDX_PIN_ENABLE  8'h21
`define KBI_IDX_BRK_CTRL    8'h40
`define KBI_IDX_EVT_STATUS  8'h41
`define KBI_IDX_EVT_MASK    8'h42

// ********************************************************************
// kbd_status_control fields
// ********************************************************************
`define KBI_SC_SENS    0
`define KBI_SC_BLOCK   1
`define KBI_SC_ACK     2
`define KBI_SC_PENDING 3

// ********************************************************************
// break control and event fields
// ********************************************************************
`define KBI_BC_CLR_EN      0
`define KBI_EVT_LATCH      0
`define KBI_EVT_ACK_BLOCK  1

// ********************************************************************
// sizes and reset values
// ********************************************************************
`define KBI_PINS      5
`define KBI_EVT_W     2
`define KBI_RST_BYTE  8'h00
`define KBI_RST_PINS  5'h1F
`define KBI_RST_EVT   2'h0

`endif

// ==== core/kbi_sync.sv ====
// two-stage synchroniser for the keyboard pins
`timescale 1ns/10ps
`default_nettype none
`include "kbi_regs.svh"

module kbi_sync (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire kbi_pkg::kbi_pins_t pin_in,
  output kbi_pkg::kbi_pins_t      pin_sync
);

  kbi_pkg::kbi_pins_t meta_ff;
  kbi_pkg::kbi_pins_t sync_ff;

  // pins idle high through the pullups, so reset to the idle level
  genvar gi;
  generate
    for (gi = 0; gi < `KBI_PINS; gi = gi + 1) begin : g_pin
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          meta_ff[gi] <= 1'b1;
          sync_ff[gi] <= 1'b1;
        end else begin
          meta_ff[gi] <= pin_in[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  assign pin_sync = sync_ff;

endmodule
`default_nettype wire

// ==== core/kbi_top.sv ====
// keyboard interrupt block: five pins, request latch, mask, break protection, wake and event interrupt
// ********************************************************************
// What this block does
// - latch a request when an enabled pin falls while all enabled pins were high
// - edge-only mode: vector fetch or software acknowledge clears the request at once
// - edge-and-level mode: clear needs acknowledge and all enabled pins high, any order
// - an enabled pin gets its pullup on and is forced to input
// - logic runs in wait; an unmasked request wakes the processor
// - logic runs in stop; an unmasked request wakes the processor
// - with break clear enabled, an acknowledge in break clears and stays cleared
// - with break clear disabled, a software acknowledge in break keeps the request and sets the ack-block event
// - upper four bits of the status and control register read zero
// - pending flag reads the request regardless of the mask; reset clears it
// - writing one to acknowledge clears the request; it reads zero always
// - mask bit set blocks requests from the processor; reset clears it
// - sensitivity bit: one is edges plus low level, zero edges only
// - five pin enables admit their pins when one; reset clears them
// ********************************************************************
`timescale 1ns/10ps
`default_nettype none
`include "kbi_regs.svh"

module kbi_top (
  input  wire logic               CORE_CLK,
  input  wire logic               NRST,
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  input  wire logic               WB_WE_I,
  input  wire logic [9:0]         WB_ADR_I,
  input  wire logic [3:0]         WB_SEL_I,
  input  wire logic [31:0]        WB_DAT_I,
  output logic      [31:0]        WB_DAT_O,
  output logic                    WB_ACK_O,
  input  wire kbi_pkg::kbi_pins_t KBD_PIN_IN,
  output kbi_pkg::kbi_pins_t      PIN_PULLUP_EN,
  output kbi_pkg::kbi_pins_t      PIN_FORCE_INPUT,
  input  wire logic               VECTOR_FETCH_ACK,
  input  wire logic               BREAK_ACTIVE,
  input  wire logic               CPU_WAIT,
  input  wire logic               CPU_STOP,
  output logic                    KBD_IRQ,
  output logic                    WAKE_REQ,
  output logic                    EVT_IRQ
);

  // ********************************************************************
  // declarations
  // ********************************************************************
  kbi_pkg::kbi_pins_t      pin_sync;
  kbi_pkg::kbi_pins_t      pin_irq_enable_bits_ff;
  logic                    trigger_sensitivity_ff;
  logic                    kbd_irq_block_ff;
  logic                    break_clear_enable_ff;
  logic                    req_ff;
  logic                    nxt_req;
  logic                    ack_pend_ff;
  logic                    nxt_ack_pend;
  logic                    any_low_ff;
  logic                    any_low;
  logic                    latch_evt;
  logic                    sw_ack;
  logic                    ack_blocked;
  logic                    ack_any;
  logic                    ack_done;
  logic [`KBI_EVT_W-1:0]   evt_sts_ff;
  logic [`KBI_EVT_W-1:0]   evt_mask_ff;
  logic [`KBI_EVT_W-1:0]   evt_set;
  logic [`KBI_EVT_W-1:0]   evt_clr;
  logic                    kbd_irq_ff;
  logic                    wake_ff;
  logic                    evt_irq_ff;
  logic                    wr_stb;
  logic [7:0]              reg_idx;
  logic [7:0]              wr_data;
  logic [7:0]              rd_data;
  logic                    wr_sc;
  logic                    wr_pe;
  logic                    wr_bc;
  logic                    wr_es;
  logic                    wr_em;

  // ********************************************************************
  // pin synchroniser and bus front end
  // ********************************************************************
  kbi_sync u_sync (
    .clk      (CORE_CLK),
    .rst_n    (NRST),
    .pin_in   (KBD_PIN_IN),
    .pin_sync (pin_sync)
  );

  kbi_wb_slave u_wb (
    .clk     (CORE_CLK),
    .rst_n   (NRST),
    .cyc     (WB_CYC_I),
    .stb     (WB_STB_I),
    .we      (WB_WE_I),
    .adr     (WB_ADR_I),
    .sel     (WB_SEL_I),
    .dat_i   (WB_DAT_I),
    .rd_data (rd_data),
    .dat_o   (WB_DAT_O),
    .ack     (WB_ACK_O),
    .wr_stb  (wr_stb),
    .reg_idx (reg_idx),
    .wr_data (wr_data)
  );

  assign wr_sc = wr_stb && (reg_idx == `KBI_IDX_STATUS_CTRL);
  assign wr_pe = wr_stb && (reg_idx == `KBI_IDX_PIN_ENABLE);
  assign wr_bc = wr_stb && (reg_idx == `KBI_IDX_BRK_CTRL);
  assign wr_es = wr_stb && (reg_idx == `KBI_IDX_EVT_STATUS);
  assign wr_em = wr_stb && (reg_idx == `KBI_IDX_EVT_MASK);

  // ********************************************************************
  // control registers
  // ********************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      trigger_sensitivity_ff <= 1'b0;
      kbd_irq_block_ff       <= 1'b0;
    end else if (wr_sc) begin
      trigger_sensitivity_ff <= wr_data[`KBI_SC_SENS];
      kbd_irq_block_ff       <= wr_data[`KBI_SC_BLOCK];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      pin_irq_enable_bits_ff <= 5'h00;
    end else if (wr_pe) begin
      pin_irq_enable_bits_ff <= wr_data[4:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      break_clear_enable_ff <= 1'b0;
    end else if (wr_bc) begin
      break_clear_enable_ff <= wr_data[`KBI_BC_CLR_EN];
    end
  end

  // ********************************************************************
  // request detection and clearing
  // ********************************************************************
  // disabled pins are excluded before the all-high test
  assign any_low   = |(~pin_sync & pin_irq_enable_bits_ff);
  assign latch_evt = any_low && !any_low_ff;

  // the acknowledge bit is write-only: it is a strobe, never stored
  assign sw_ack      = wr_sc && wr_data[`KBI_SC_ACK];
  assign ack_blocked = sw_ack && BREAK_ACTIVE && !break_clear_enable_ff;
  assign ack_any     = VECTOR_FETCH_ACK || (sw_ack && !ack_blocked);
  assign ack_done    = ack_any || ack_pend_ff;

  // a new falling edge in the acknowledge cycle wins and relatches
  always_comb begin
    if (trigger_sensitivity_ff) begin
      nxt_req      = latch_evt || (req_ff && !(ack_done && !any_low));
      nxt_ack_pend = nxt_req && !latch_evt && ack_done;
    end else begin
      nxt_req      = latch_evt || (req_ff && !ack_any);
      nxt_ack_pend = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      req_ff      <= 1'b0;
      ack_pend_ff <= 1'b0;
      any_low_ff  <= 1'b0;
    end else begin
      req_ff      <= nxt_req;
      ack_pend_ff <= nxt_ack_pend;
      any_low_ff  <= any_low;
    end
  end

  // ********************************************************************
  // event status, mask and interrupt output
  // ********************************************************************
  assign evt_set = {ack_blocked, latch_evt};
  assign evt_clr = wr_es ? wr_data[`KBI_EVT_W-1:0] : `KBI_RST_EVT;

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      evt_sts_ff <= `KBI_RST_EVT;
    end else begin
      evt_sts_ff <= (evt_sts_ff & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      evt_mask_ff <= `KBI_RST_EVT;
    end else if (wr_em) begin
      evt_mask_ff <= wr_data[`KBI_EVT_W-1:0];
    end
  end

  // ********************************************************************
  // outputs to the processor and the pads
  // ********************************************************************
  // the logic is never clock-gated, so wait and stop only steer the wake line
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      kbd_irq_ff <= 1'b0;
      wake_ff    <= 1'b0;
      evt_irq_ff <= 1'b0;
    end else begin
      kbd_irq_ff <= req_ff && !kbd_irq_block_ff;
      wake_ff    <= req_ff && !kbd_irq_block_ff && (CPU_WAIT || CPU_STOP);
      evt_irq_ff <= |(evt_sts_ff & evt_mask_ff);
    end
  end

  assign KBD_IRQ         = kbd_irq_ff;
  assign WAKE_REQ        = wake_ff;
  assign EVT_IRQ         = evt_irq_ff;
  assign PIN_PULLUP_EN   = pin_irq_enable_bits_ff;
  assign PIN_FORCE_INPUT = pin_irq_enable_bits_ff;

  // ********************************************************************
  // read data mux
  // ********************************************************************
  always_comb begin
    rd_data = `KBI_RST_BYTE;
    unique case (reg_idx)
      `KBI_IDX_STATUS_CTRL: begin
        // upper nibble and the acknowledge bit stay zero
        rd_data[`KBI_SC_PENDING] = req_ff;
        rd_data[`KBI_SC_BLOCK]   = kbd_irq_block_ff;
        rd_data[`KBI_SC_SENS]    = trigger_sensitivity_ff;
      end
      `KBI_IDX_PIN_ENABLE: begin
        rd_data[4:0] = pin_irq_enable_bits_ff;
      end
      `KBI_IDX_BRK_CTRL: begin
        rd_data[`KBI_BC_CLR_EN] = break_clear_enable_ff;
      end
      `KBI_IDX_EVT_STATUS: begin
        rd_data[`KBI_EVT_W-1:0] = evt_sts_ff;
      end
      `KBI_IDX_EVT_MASK: begin
        rd_data[`KBI_EVT_W-1:0] = evt_mask_ff;
      end
      default: begin
        rd_data = `KBI_RST_BYTE;
      end
    endcase
  end

  // ********************************************************************
  // assertions
  // ********************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  sequence s_fall_seen;
    latch_evt;
  endsequence

  sequence s_sw_ack_in_break;
    BREAK_ACTIVE && sw_ack;
  endsequence

  sequence s_pe_write;
    wr_pe;
  endsequence

  a_latch_on_fall: assert property (s_fall_seen |=> req_ff ##1 (req_ff || !trigger_sensitivity_ff))
    else $error("falling pin did not latch a request");

  a_edge_ack_clear: assert property (!trigger_sensitivity_ff && ack_any && !latch_evt |=> !req_ff)
    else $error("edge mode acknowledge did not clear the request");

  a_level_hold_low: assert property (trigger_sensitivity_ff && any_low && req_ff |=> req_ff)
    else $error("level mode request dropped while a pin is low");

  a_level_ack_then_high: assert property
    (trigger_sensitivity_ff && req_ff && ack_any && !latch_evt ##1 !any_low && trigger_sensitivity_ff && !latch_evt
     |=> !req_ff)
    else $error("level mode request stayed after acknowledge and all pins high");

  a_pin_enable_pads: assert property (s_pe_write |=> PIN_PULLUP_EN == $past(wr_data[4:0]) &&
                                      PIN_FORCE_INPUT == $past(wr_data[4:0]))
    else $error("pad controls do not follow the pin enables");

  a_wake_from_wait: assert property (req_ff && !kbd_irq_block_ff && CPU_WAIT |=> WAKE_REQ)
    else $error("unmasked request did not wake from wait");

  a_wake_from_stop: assert property (req_ff && !kbd_irq_block_ff && CPU_STOP |=> WAKE_REQ)
    else $error("unmasked request did not wake from stop");

  a_break_clear_ok: assert property ((s_sw_ack_in_break and (break_clear_enable_ff && !trigger_sensitivity_ff
                                     && !latch_evt)) |=> !req_ff)
    else $error("enabled break clear did not clear the request");

  a_break_protect: assert property ((s_sw_ack_in_break and (!break_clear_enable_ff && !VECTOR_FETCH_ACK
                                    && !ack_pend_ff && req_ff)) |=> req_ff && evt_sts_ff[`KBI_EVT_ACK_BLOCK])
    else $error("protected break acknowledge changed the request");

  a_sc_read_bits: assert property (reg_idx == `KBI_IDX_STATUS_CTRL |-> rd_data[7:4] == 4'h0 &&
                                   !rd_data[`KBI_SC_ACK] && rd_data[`KBI_SC_PENDING] == req_ff)
    else $error("status and control read shows wrong fixed bits or pending flag");

  a_irq_masked: assert property (kbd_irq_block_ff |=> !KBD_IRQ)
    else $error("masked request reached the processor");

  a_irq_follows: assert property (req_ff && !kbd_irq_block_ff |=> KBD_IRQ)
    else $error("unmasked request did not reach the processor");

endmodule
`default_nettype wire

// ==== core/kbi_wb_slave.sv ====
// classic wishbone slave front end for the keyboard interrupt registers
`timescale 1ns/10ps
`default_nettype none
`include "kbi_regs.svh"

module kbi_wb_slave (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cyc,
  input  wire logic        stb,
  input  wire logic        we,
  input  wire logic [9:0]  adr,
  input  wire logic [3:0]  sel,
  input  wire logic [31:0] dat_i,
  input  wire logic [7:0]  rd_data,
  output logic      [31:0] dat_o,
  output logic             ack,
  output logic             wr_stb,
  output logic      [7:0]  reg_idx,
  output logic      [7:0]  wr_data
);

  kbi_pkg::kbi_wb_state_t state_ff;
  kbi_pkg::kbi_wb_state_t nxt_state;
  logic                   take;
  logic                   ack_ff;
  logic [31:0]            dat_ff;

  // the ack cycle separates two requests, so one access is taken once
  assign take    = cyc && stb && (state_ff == kbi_pkg::KBI_WB_IDLE);
  assign reg_idx = adr[9:2];
  assign wr_data = dat_i[7:0];
  assign wr_stb  = take && we && sel[0];

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      kbi_pkg::KBI_WB_IDLE: begin
        if (take) begin
          nxt_state = kbi_pkg::KBI_WB_ACK;
        end
      end
      kbi_pkg::KBI_WB_ACK: begin
        nxt_state = kbi_pkg::KBI_WB_IDLE;
      end
      default: begin
        nxt_state = kbi_pkg::KBI_WB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= kbi_pkg::KBI_WB_IDLE;
      ack_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ack_ff   <= take;
    end
  end

  // unmapped indices read as zero because the data mux defaults to zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dat_ff <= 32'h0000_0000;
    end else if (take && !we) begin
      dat_ff <= {24'h00_0000, rd_data};
    end else begin
      dat_ff <= 32'h0000_0000;
    end
  end

  assign ack   = ack_ff;
  assign dat_o = dat_ff;

endmodule
`default_nettype wire

// ==== verif/kbi_keys_model.sv ====
// model of the keys and switches hanging on the five keyboard pins
`timescale 1ns/10ps
`default_nettype none
module kbi_keys_model (
  input  wire logic               clk,
  input  wire kbi_pkg::kbi_pins_t press,
  input  wire kbi_pkg::kbi_pins_t pull_en,
  input  wire kbi_pkg::kbi_pins_t drive_hi,
  output kbi_pkg::kbi_pins_t      pins
);
  // an unpulled, undriven, released pin floats: show a changing pattern, never a clean level
  kbi_pkg::kbi_pins_t float_ff = 5'h15;
  always @(posedge clk) begin
    float_ff <= ~float_ff;
  end
  // a closed key pulls low; an open key reads high through the pullup or a port driven high
  assign pins = ~press & (pull_en | drive_hi | float_ff);
endmodule
`default_nettype wire

// ==== verif/kbi_top_tb.sv ====
// self-checking bench of the keyboard interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "kbi_regs.svh"
module kbi_top_tb;
  logic               clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic               vfa = 1'b0, brk = 1'b0, cwait = 1'b0, cstop = 1'b0;
  logic [9:0]         adr = 10'h000;
  logic [3:0]         sel = 4'h0;
  logic [31:0]        dat = 32'h0, rdat;
  logic               ack, kirq, wake, eirq;
  kbi_pkg::kbi_pins_t pins, pull, force_in, press = 5'h00, drv = 5'h00;
  int                 num_errors = 0, samples_checked = 0;
  logic [31:0]        seed = 32'h3;
  logic [7:0]         q;
  logic [4:0]         k;
  bit                 m_sens, m_block, m_req, m_ackd, m_bce;
  logic [4:0]         m_en = 5'h00, m_low = 5'h00;
  logic [1:0]         m_evt = 2'h0, m_emask = 2'h0;

  always #10 clk = ~clk;

  kbi_top uut (.CORE_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .KBD_PIN_IN(pins), .PIN_PULLUP_EN(pull), .PIN_FORCE_INPUT(force_in), .VECTOR_FETCH_ACK(vfa),
    .BREAK_ACTIVE(brk), .CPU_WAIT(cwait), .CPU_STOP(cstop), .KBD_IRQ(kirq), .WAKE_REQ(wake),
    .EVT_IRQ(eirq));
  kbi_keys_model keys (.clk(clk), .press(press), .pull_en(pull), .drive_hi(drv), .pins(pins));

  // ********************************************************************
  // helpers
  // ********************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task final_report;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // entered at a rising edge; holds the request until ack is sampled high
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; sel <= 4'hF; dat <= {24'h0, d};
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) num_errors++;
    q = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [7:0] sc();
    return {6'h0, m_block, m_sens};
  endfunction

  task press_keys(input logic [4:0] keys_dn);
    if ((m_en & m_low) == 5'h0 && (m_en & keys_dn) != 5'h0) begin
      m_req = 1'b1;
      m_evt[0] = 1'b1;
    end
    m_low = keys_dn;
    if (m_sens && m_ackd && (m_en & m_low) == 5'h0) {m_req, m_ackd} = 2'b00;
    press <= keys_dn;
    repeat (6) @(posedge clk);
  endtask

  task ack_model(input bit sw);
    if (sw && brk && !m_bce) m_evt[1] = 1'b1;
    else if (m_sens && (m_en & m_low) != 5'h0) m_ackd = 1'b1;
    else {m_req, m_ackd} = 2'b00;
  endtask

  task sw_ack;
    bus(1'b1, `KBI_IDX_STATUS_CTRL, 8'hF4 | sc());
    ack_model(1'b1);
  endtask

  task check_state;
    bus(1'b0, `KBI_IDX_STATUS_CTRL, 8'h00);
    check(q, {4'h0, m_req, 1'b0, m_block, m_sens});
    check({7'h0, kirq}, {7'h0, m_req & ~m_block});
    check({7'h0, wake}, {7'h0, m_req & ~m_block & (cwait | cstop)});
    bus(1'b0, `KBI_IDX_EVT_STATUS, 8'h00);
    check(q, {6'h0, m_evt});
    check({7'h0, eirq}, {7'h0, |(m_evt & m_emask)});
  endtask

  // ********************************************************************
  // scenarios
  // ********************************************************************
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    check_state;
    bus(1'b0, `KBI_IDX_PIN_ENABLE, 8'h00);
    check(q, 8'h00);
    // masked while pullups charge, so the false latch never reaches the cpu
    m_block = 1'b1;
    bus(1'b1, `KBI_IDX_STATUS_CTRL, sc());
    m_en = 5'h1F;
    bus(1'b1, `KBI_IDX_PIN_ENABLE, 8'hFF);
    bus(1'b0, `KBI_IDX_PIN_ENABLE, 8'h00);
    check(q, 8'h1F);
    check({3'h0, pull}, 8'h1F);
    check({3'h0, force_in}, 8'h1F);
    repeat (8) @(posedge clk);
    sw_ack;
    m_block = 1'b0;
    bus(1'b1, `KBI_IDX_STATUS_CTRL, sc());
    bus(1'b1, `KBI_IDX_EVT_STATUS, 8'h03);
    m_evt = 2'h0;
    m_emask = 2'h3;
    bus(1'b1, `KBI_IDX_EVT_MASK, 8'h03);
    check_state;
    for (int mode = 0; mode < 2; mode++) begin
      m_sens = mode[0];
      cwait <= ~mode[0];
      cstop <= mode[0];
      bus(1'b1, `KBI_IDX_STATUS_CTRL, sc());
      k = 5'h01 << (rnd() % 5);
      press_keys(k);
      check_state;
      m_block = 1'b1;
      bus(1'b1, `KBI_IDX_STATUS_CTRL, sc());
      check_state;
      m_block = 1'b0;
      sw_ack;
      check_state;
      press_keys(k | {k[3:0], k[4]});
      check_state;
      press_keys(5'h00);
      check_state;
      bus(1'b1, `KBI_IDX_EVT_STATUS, 8'h01);
      m_evt[0] = 1'b0;
      press_keys(k);
      press_keys(5'h00);
      check_state;
      vfa <= 1'b1;
      @(posedge clk);
      vfa <= 1'b0;
      ack_model(1'b0);
      repeat (3) @(posedge clk);
      check_state;
    end
    brk <= 1'b1;
    m_bce = 1'b0;
    bus(1'b1, `KBI_IDX_BRK_CTRL, 8'h00);
    press_keys(5'h04);
    sw_ack;
    check_state;
    m_bce = 1'b1;
    bus(1'b1, `KBI_IDX_BRK_CTRL, 8'h01);
    sw_ack;
    brk <= 1'b0;
    press_keys(5'h00);
    check_state;
    bus(1'b1, 8'h05, 8'hFF);
    bus(1'b0, 8'h05, 8'h00);
    check(q, 8'h00);
    // second way in: ports driven high before the pin is enabled again
    m_en = 5'h00;
    bus(1'b1, `KBI_IDX_PIN_ENABLE, 8'h00);
    drv <= 5'h1F;
    repeat (4) @(posedge clk);
    m_en = 5'h01;
    bus(1'b1, `KBI_IDX_PIN_ENABLE, 8'h01);
    check({3'h0, pull}, 8'h01);
    check_state;
    press_keys(5'h1E);
    check_state;
    final_report;
  end

  initial begin
    #400000;
    num_errors++;
    final_report;
  end
endmodule
`default_nettype wire
